// [src/acc_pkg.sv]
// Constants, types and helpers of the analog comparator control block.
// =====================================================================
// Functional notes
// - Mode value two selects user single measurement.
// - Software writes user start to launch one.
// - Wait startup, compare, update status, raise events.
// - Hardware clears user start after comparison.
// - Mode three plus trigger enable: event mode.
// - Incoming event sets event start automatically.
// - Hardware clears event start after comparison.
// - No further comparisons until new start.
// - Negative input: own pin or shared reference.
// - Normal mode routes inputs by select fields.
// - Interrupt asserted only while mask bit set.
// - Enable sets mask, disable clears, zeros ignored.
// - Interrupt holds until status bit cleared.
// - At most one peripheral event per comparison.
// - Comparators in normal mode work independently.
`default_nettype none
package acc_pkg;
  localparam int ACC_NCMP = 4;
  localparam int ACC_AW = 8;
  localparam int ACC_STUP_W = 16;
  localparam int ACC_BYTES = 4;
  localparam int ACC_BYTE_W = 8;
  // =================================================================
  // Register offsets.
  localparam logic [7:0] ACC_CTRL_OFS = 8'h00;
  localparam logic [7:0] ACC_STUP_OFS = 8'h04;
  localparam logic [7:0] ACC_STAT_OFS = 8'h08;
  localparam logic [7:0] ACC_ISR_OFS = 8'h0C;
  localparam logic [7:0] ACC_IER_OFS = 8'h10;
  localparam logic [7:0] ACC_IDR_OFS = 8'h14;
  localparam logic [7:0] ACC_IMR_OFS = 8'h18;
  localparam logic [7:0] ACC_ICR_OFS = 8'h1C;
  localparam logic [7:0] ACC_CONF0_OFS = 8'h20;
  localparam logic [7:0] ACC_CONF_STEP = 8'h04;
  // =================================================================
  // Field positions and values.
  localparam int ACC_CTRL_USER_SINGLE_START = 0;
  localparam int ACC_CTRL_EVENT_SINGLE_START = 1;
  localparam int ACC_CTRL_EVTEN = 2;
  localparam int ACC_CONF_MODE = 0;
  localparam int ACC_CONF_NSEL = 4;
  localparam int ACC_CONF_PSEL = 5;
  localparam int ACC_CONF_EVO = 8;
  localparam logic [1:0] ACC_MODE_OFF = 2'h0;
  localparam logic [1:0] ACC_MODE_USER = 2'h2;
  localparam logic [1:0] ACC_MODE_EVENT = 2'h3;
  localparam logic [15:0] ACC_STUP_RST = 16'h0020;
  localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ACC_IDLE, ACC_WAIT} acc_state_t;
  // =================================================================
  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] acc_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    for (int b = 0; b < ACC_BYTES; b++) begin
      m[b*ACC_BYTE_W +: ACC_BYTE_W] = {ACC_BYTE_W{strb[b]}};
    end
    return (old & ~m) | (nw & m);
  endfunction : acc_merge
  // Byte address of configuration word i.
  function automatic logic [7:0] acc_conf_ofs(input int i);
    return ACC_CONF0_OFS + ACC_CONF_STEP * 8'(i);
  endfunction : acc_conf_ofs
  // Packs the fields of one configuration word.
  function automatic logic [31:0] acc_conf_word(input logic [1:0] md,
      input logic ns, input logic ps, input logic eo);
    logic [31:0] w;
    w = '0;
    w[ACC_CONF_MODE +: 2] = md;
    w[ACC_CONF_NSEL] = ns;
    w[ACC_CONF_PSEL] = ps;
    w[ACC_CONF_EVO] = eo;
    return w;
  endfunction : acc_conf_word
endpackage : acc_pkg
`default_nettype wire

// [src/acc_sync.sv]
// Three-stage synchroniser with agreement filter for comparator outputs.
`default_nettype none
module acc_sync
  import acc_pkg::*;
#(
  parameter int W = ACC_NCMP
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } acc_sync_t;
  acc_sync_t q, d;
  // =================================================================
  // Only the second and third stages are compared; the first one may be
  // metastable and feeds nothing but the second.
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.val[i] = q.s3[i];
      end
    end
  end
  // State register.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
  assign dout = q.val;
endmodule : acc_sync
`default_nettype wire

// [src/acc_timer.sv]
// Startup delay counter: loaded on request, ends in a one-cycle pulse.
`default_nettype none
module acc_timer
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire logic [ACC_STUP_W-1:0] dur,
  output logic done
);
  typedef struct packed {
    logic [ACC_STUP_W-1:0] cnt;
    logic run;
    logic done;
  } acc_tmr_t;
  acc_tmr_t q, d;
  // =================================================================
  // A load restarts the count; zero ends it one cycle later.
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (load) begin
      d.cnt = dur;
      d.run = 1'b1;
    end else if (q.run) begin
      if (q.cnt == '0) begin
        d.run = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end
  // State register.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
  assign done = q.done;
endmodule : acc_timer
`default_nettype wire

// [src/acc_ctrl.sv]
// Control front end of the analog comparator bank with its register file.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`default_nettype none
module acc_ctrl
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [ACC_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ACC_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [ACC_NCMP-1:0] comparator_output,
  input wire logic event_in,
  output logic event_out,
  output logic [ACC_NCMP-1:0] negative_input_select,
  output logic [ACC_NCMP-1:0] positive_input_select,
  output logic irq
);
  // =================================================================
  // Whole state of the block, except the synchroniser and startup timer stages.
  typedef struct packed {
    acc_state_t st;
    logic src_evt;
    logic [ACC_NCMP-1:0] tgt;
    logic user_single_start;
    logic event_single_start;
    logic event_trigger_enable;
    logic [ACC_STUP_W-1:0] stup;
    logic [ACC_NCMP-1:0][1:0] comparator_mode_field;
    logic [ACC_NCMP-1:0] nsel;
    logic [ACC_NCMP-1:0] psel;
    logic [ACC_NCMP-1:0] evo;
    logic [ACC_NCMP-1:0] stat;
    logic [ACC_NCMP-1:0] interrupt_status_reg;
    logic [ACC_NCMP-1:0] interrupt_mask_reg;
    logic evt_out;
    logic irq;
    logic awr;
    logic bv;
    logic [1:0] bresp;
    logic arr;
    logic rv;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } acc_regs_t;
  acc_regs_t q, d;
  logic wr_go;
  logic rd_go;
  logic tmr_load;
  logic tmr_done;
  logic [ACC_NCMP-1:0] cmp_s;
  logic [ACC_NCMP-1:0] ier_w;
  logic [ACC_NCMP-1:0] idr_w;
  logic [ACC_NCMP-1:0] icr_w;
  logic [ACC_NCMP-1:0] isr_set;
  logic ust_set;
  logic ust_clr;
  logic est_set;
  logic est_clr;
  logic [31:0] wv;
  logic [31:0] rv;
  logic wr_hit;
  logic rd_hit;

  // =================================================================
  // Comparator results arrive from the analog cores, asynchronous to us.
  acc_sync #(
    .W(ACC_NCMP)
  ) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .din(comparator_output),
    .dout(cmp_s)
  );

  // Startup delay before a result may be trusted.
  acc_timer u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .load(tmr_load),
    .dur(q.stup),
    .done(tmr_done)
  );

  // =================================================================
  // A request is taken once; the ready pulse completes the handshake
  // because the master holds valid until then.
  assign wr_go = awvalid && wvalid && !q.awr && !q.bv;
  assign rd_go = arvalid && !q.arr && !q.rv;

  // =================================================================
  // Next-state logic: bus, register writes, sequencer and flags.
  always_comb begin
    d = q;
    d.evt_out = 1'b0;
    tmr_load = 1'b0;
    ier_w = '0;
    idr_w = '0;
    icr_w = '0;
    isr_set = '0;
    ust_set = 1'b0;
    ust_clr = 1'b0;
    est_set = 1'b0;
    est_clr = 1'b0;
    wv = '0;
    rv = '0;
    wr_hit = 1'b1;
    rd_hit = 1'b1;

    // Write channel: ready pulse, then response until taken.
    d.awr = wr_go;
    if (q.awr) begin
      d.bv = 1'b1;
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end

    // Register writes; status registers ignore writes quietly.
    if (wr_go) begin
      if (awaddr == ACC_CTRL_OFS) begin
        wv = acc_merge('0, wdata, wstrb);
        // The enable is a stored bit: a write with its byte lane masked keeps it,
        // while the start bits below are only set where the lane is written.
        if (wstrb[ACC_CTRL_EVTEN / ACC_BYTE_W]) begin
          d.event_trigger_enable = wv[ACC_CTRL_EVTEN];
        end
        ust_set = wv[ACC_CTRL_USER_SINGLE_START];
        est_set = wv[ACC_CTRL_EVENT_SINGLE_START];
      end else if (awaddr == ACC_STUP_OFS) begin
        wv = acc_merge(32'(q.stup), wdata, wstrb);
        d.stup = wv[ACC_STUP_W-1:0];
      end else if (awaddr == ACC_IER_OFS) begin
        wv = acc_merge('0, wdata, wstrb);
        ier_w = wv[ACC_NCMP-1:0];
      end else if (awaddr == ACC_IDR_OFS) begin
        wv = acc_merge('0, wdata, wstrb);
        idr_w = wv[ACC_NCMP-1:0];
      end else if (awaddr == ACC_ICR_OFS) begin
        wv = acc_merge('0, wdata, wstrb);
        icr_w = wv[ACC_NCMP-1:0];
      end else if (awaddr == ACC_STAT_OFS || awaddr == ACC_ISR_OFS
                   || awaddr == ACC_IMR_OFS) begin
        wr_hit = 1'b1;
      end else begin
        wr_hit = 1'b0;
        for (int i = 0; i < ACC_NCMP; i++) begin
          if (awaddr == acc_conf_ofs(i)) begin
            wr_hit = 1'b1;
            wv = acc_merge(acc_conf_word(q.comparator_mode_field[i],
                 q.nsel[i], q.psel[i], q.evo[i]), wdata, wstrb);
            d.comparator_mode_field[i] = wv[ACC_CONF_MODE +: 2];
            d.nsel[i] = wv[ACC_CONF_NSEL];
            d.psel[i] = wv[ACC_CONF_PSEL];
            d.evo[i] = wv[ACC_CONF_EVO];
          end
        end
      end
      d.bresp = wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end

    // Read channel: data captured at the request, shown one cycle later.
    d.arr = rd_go;
    if (q.arr) begin
      d.rv = 1'b1;
    end
    if (q.rv && rready) begin
      d.rv = 1'b0;
    end
    if (rd_go) begin
      if (araddr == ACC_CTRL_OFS) begin
        rv[ACC_CTRL_USER_SINGLE_START] = q.user_single_start;
        rv[ACC_CTRL_EVENT_SINGLE_START] = q.event_single_start;
        rv[ACC_CTRL_EVTEN] = q.event_trigger_enable;
      end else if (araddr == ACC_STUP_OFS) begin
        rv[ACC_STUP_W-1:0] = q.stup;
      end else if (araddr == ACC_STAT_OFS) begin
        rv[ACC_NCMP-1:0] = q.stat;
      end else if (araddr == ACC_ISR_OFS) begin
        rv[ACC_NCMP-1:0] = q.interrupt_status_reg;
      end else if (araddr == ACC_IMR_OFS) begin
        rv[ACC_NCMP-1:0] = q.interrupt_mask_reg;
      end else if (araddr == ACC_IER_OFS || araddr == ACC_IDR_OFS
                   || araddr == ACC_ICR_OFS) begin
        rd_hit = 1'b1;
      end else begin
        rd_hit = 1'b0;
        for (int i = 0; i < ACC_NCMP; i++) begin
          if (araddr == acc_conf_ofs(i)) begin
            rd_hit = 1'b1;
            rv = acc_conf_word(q.comparator_mode_field[i], q.nsel[i],
                 q.psel[i], q.evo[i]);
          end
        end
      end
      d.rdata = rv;
      d.rresp = rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end

    // Measurement sequencer. The user start wins when both are pending;
    // the event start then runs as the next comparison.
    case (q.st)
      ACC_IDLE: begin
        if (q.user_single_start || q.event_single_start) begin
          d.src_evt = !q.user_single_start;
          for (int i = 0; i < ACC_NCMP; i++) begin
            if (q.user_single_start) begin
              d.tgt[i] = q.comparator_mode_field[i] == ACC_MODE_USER;
            end else begin
              d.tgt[i] = q.comparator_mode_field[i] == ACC_MODE_EVENT
                         && q.event_trigger_enable;
            end
          end
          tmr_load = 1'b1;
          d.st = ACC_WAIT;
        end
      end
      ACC_WAIT: begin
        if (tmr_done) begin
          // Each comparator is sampled on its own; the analog core
          // already drives high when its positive input is higher.
          for (int i = 0; i < ACC_NCMP; i++) begin
            if (q.tgt[i]) begin
              d.stat[i] = cmp_s[i];
            end
          end
          isr_set = q.tgt;
          d.evt_out = |(q.tgt & q.evo);
          ust_clr = !q.src_evt;
          est_clr = q.src_evt;
          d.st = ACC_IDLE;
        end
      end
      default: begin
        d.st = ACC_IDLE;
      end
    endcase

    // Flag updates: on the start and status flags a set arriving with a clear wins,
    // so no start and no status event is lost; on the mask a disable wins.
    d.user_single_start = (q.user_single_start & ~ust_clr) | ust_set;
    d.event_single_start = (q.event_single_start & ~est_clr) | est_set
                           | (q.event_trigger_enable & event_in);
    d.interrupt_status_reg = (q.interrupt_status_reg & ~(icr_w | idr_w)) | isr_set;
    d.interrupt_mask_reg = (q.interrupt_mask_reg | ier_w) & ~idr_w;
    d.irq = |(d.interrupt_status_reg & d.interrupt_mask_reg);
  end

  // =================================================================
  // State register; a low clock enable freezes everything.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      q <= '0;
      q.stup <= ACC_STUP_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops.
  assign awready = q.awr;
  assign wready = q.awr;
  assign bvalid = q.bv;
  assign bresp = q.bresp;
  assign arready = q.arr;
  assign rvalid = q.rv;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign event_out = q.evt_out;
  assign irq = q.irq;
  // Select fields drive the analog muxes in every comparator mode, off included.
  assign negative_input_select = q.nsel;
  assign positive_input_select = q.psel;

  // =================================================================
  // Checks on the sequencer, flags and interrupt path.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic clr_wr;
  assign clr_wr = wr_go && (awaddr == ACC_IDR_OFS || awaddr == ACC_ICR_OFS);

  mode_user_a: assert property (ce && q.st == ACC_WAIT && tmr_done && !q.src_evt
    && q.comparator_mode_field[0] == ACC_MODE_USER |=> q.interrupt_status_reg[0])
    else $error("user mode comparator 0 not sampled");
  user_start_a: assert property (ce && q.st == ACC_IDLE && q.user_single_start
    |=> q.st == ACC_WAIT && !q.src_evt)
    else $error("user start did not launch a comparison");
  stup_wait_a: assert property (ce && tmr_load && q.stup != '0
    |=> q.st == ACC_WAIT && $stable(q.stat) ##1 !tmr_done)
    else $error("comparison did not wait for startup");
  user_single_start_clr_a: assert property (ce && q.st == ACC_WAIT && tmr_done && !q.src_evt
    && !(wr_go && awaddr == ACC_CTRL_OFS) |=> !q.user_single_start)
    else $error("user start not cleared after comparison");
  event_single_start_set_a: assert property (ce && q.event_trigger_enable && event_in
    |=> q.event_single_start)
    else $error("event did not set event start");
  event_single_start_clr_a: assert property (ce && q.st == ACC_WAIT && tmr_done && q.src_evt
    && !event_in && !(wr_go && awaddr == ACC_CTRL_OFS) |=> !q.event_single_start)
    else $error("event start not cleared after comparison");
  single_run_a: assert property (ce && q.st == ACC_WAIT && tmr_done
    && !d.user_single_start && !d.event_single_start |=> ##1 q.st == ACC_IDLE)
    else $error("comparison repeated without new start");
  irq_mask_a: assert property (q.irq |-> |(q.interrupt_status_reg & q.interrupt_mask_reg))
    else $error("interrupt without enabled status");
  mask_set_a: assert property (ce && wr_go && awaddr == ACC_IER_OFS
    && wstrb[0] && wdata[0] |=> q.interrupt_mask_reg[0])
    else $error("enable write did not set mask");
  irq_hold_a: assert property (ce && q.irq && !clr_wr |=> q.irq)
    else $error("interrupt dropped before status clear");
  one_event_a: assert property (ce && q.evt_out |=> !q.evt_out)
    else $error("more than one event per comparison");
  // A low enable must hold every register, the bus handshake included, so a
  // stalled clock tree never shortens the startup wait.
  ce_freeze_a: assert property (!ce |=> $stable(q))
    else $error("state moved while clock enable low");

  user_run_c: cover property (q.st == ACC_WAIT && tmr_done && !q.src_evt);
  event_run_c: cover property (q.st == ACC_WAIT && tmr_done && q.src_evt);
  irq_fire_c: cover property ($rose(q.irq));
  event_out_c: cover property (q.evt_out);
  wait_frozen_c: cover property (q.st == ACC_WAIT && !ce);
endmodule : acc_ctrl
`default_nettype wire

// [tb/acc_cmp_model.sv]
// Behavioural model of the analog comparator cores and of the event source.
`default_nettype none
module acc_cmp_model
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic [ACC_NCMP-1:0][7:0] pos_lvl,
  input wire logic [ACC_NCMP-1:0][7:0] neg_lvl,
  input wire logic [7:0] ref_lvl,
  input wire logic [ACC_NCMP-1:0] negative_input_select,
  input wire logic [ACC_NCMP-1:0] positive_input_select,
  input wire logic fire,
  output logic [ACC_NCMP-1:0] comparator_output,
  output logic event_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // Cores
  // Each core compares on its own; a select picks the own pin or the shared level.
  always_comb begin
    for (int i = 0; i < ACC_NCMP; i++) begin
      comparator_output[i] = (positive_input_select[i] ? ref_lvl : pos_lvl[i]) >
          (negative_input_select[i] ? ref_lvl : neg_lvl[i]);
    end
  end
  // =====================================================================
  // Event source
  // One-cycle event, registered so it never changes on the sampling edge.
  initial event_in = 1'b0;
  always @(posedge core_clk) begin
    event_in <= fire;
  end
endmodule : acc_cmp_model
`default_nettype wire

// [tb/analog_comparator_control_tb.sv]
// Self-checking testbench of the analog comparator control block.
`default_nettype none
module analog_comparator_control_tb;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, nrst, ce, fire;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, event_in, event_out, irq;
  logic [ACC_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [ACC_NCMP-1:0] cmp_out, nsel, psel;
  logic [ACC_NCMP-1:0][7:0] pos_lvl, neg_lvl;
  logic [7:0] ref_lvl;
  int n_mismatch = 0;
  int check_count = 0;
  int ev_cnt = 0;
  acc_ctrl i_acc_ctrl (.core_clk(core_clk), .nrst(nrst), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .comparator_output(cmp_out), .event_in(event_in),
    .event_out(event_out), .negative_input_select(nsel), .positive_input_select(psel),
    .irq(irq));
  acc_cmp_model i_acc_cmp_model (.core_clk(core_clk), .pos_lvl(pos_lvl), .neg_lvl(neg_lvl),
    .ref_lvl(ref_lvl), .negative_input_select(nsel), .positive_input_select(psel),
    .fire(fire), .comparator_output(cmp_out), .event_in(event_in));
  // =====================================================================
  // Clock, event counter and watchdog
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (event_out === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  // The whole run needs a few hundred cycles; this cuts a hung handshake short.
  initial begin
    #50us;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
  // =====================================================================
  // Shared tasks
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  // Each task is entered just after a rising edge and leaves one edge after
  // its last strobe drops, so no strobe is assigned twice in one time step.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge core_clk); n++; end while (!(awready === 1'b1 && wready === 1'b1) && n < 50);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge core_clk); n++; end while (bvalid !== 1'b1 && n < 50);
    chk(n < 50 && bresp === er, "write response");
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge core_clk); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge core_clk); n++; end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    chk(n < 50 && rresp === er, "read response");
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_rd
  // Polls the control word until the given start bit has dropped.
  task automatic wait_clear(input int b);
    logic [31:0] d;
    int k;
    d = 32'hFFFFFFFF;
    k = 0;
    while (d[b] !== 1'b0 && k < 20) begin
      axi_rd(ACC_CTRL_OFS, d, ACC_RESP_OKAY);
      k++;
    end
    chk(d[b] === 1'b0, "start bit never cleared");
  endtask : wait_clear
  task automatic pulse_event;
    fire <= 1'b1;
    @(posedge core_clk);
    fire <= 1'b0;
    @(posedge core_clk);
  endtask : pulse_event
  // =====================================================================
  // Scenarios
  task automatic check_reset_and_map;
    logic [31:0] d;
    axi_rd(ACC_STUP_OFS, d, ACC_RESP_OKAY);
    chk(d[15:0] === ACC_STUP_RST, "startup reset value");
    axi_rd(ACC_IMR_OFS, d, ACC_RESP_OKAY);
    chk(d === 32'h00000000, "mask reset value");
    axi_rd(8'hF0, d, ACC_RESP_SLVERR);
    axi_wr(8'hF0, 32'h00000001, ACC_RESP_SLVERR);
  endtask : check_reset_and_map
  // Comparator 0 on its own pin, 1 against the shared level, 2 left idle.
  task automatic user_single;
    logic [31:0] d;
    axi_wr(ACC_STUP_OFS, 32'h00000004, ACC_RESP_OKAY);
    axi_wr(ACC_CONF0_OFS, 32'h00000102, ACC_RESP_OKAY);
    axi_wr(ACC_CONF0_OFS + 8'h04, 32'h00000012, ACC_RESP_OKAY);
    axi_wr(ACC_CONF0_OFS + 8'h08, 32'h00000020, ACC_RESP_OKAY);
    repeat (8) @(posedge core_clk);
    chk(nsel === 4'h2 && psel === 4'h4, "input select routing");
    axi_rd(ACC_CONF0_OFS + 8'h08, d, ACC_RESP_OKAY);
    chk(d === 32'h00000020, "config readback");
    axi_wr(ACC_CTRL_OFS, 32'h00000001, ACC_RESP_OKAY);
    wait_clear(0);
    axi_rd(ACC_STAT_OFS, d, ACC_RESP_OKAY);
    chk(d[2:0] === 3'h1, "comparison result");
    axi_rd(ACC_ISR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h3, "done flags");
    chk(ev_cnt === 1, "one event per comparison");
    chk(irq === 1'b0, "interrupt while masked");
    axi_wr(ACC_ICR_OFS, 32'h0000000F, ACC_RESP_OKAY);
    repeat (40) @(posedge core_clk);
    axi_rd(ACC_ISR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h0 && ev_cnt === 1, "comparison repeated");
  endtask : user_single
  task automatic irq_masking;
    logic [31:0] d;
    axi_wr(ACC_CTRL_OFS, 32'h00000001, ACC_RESP_OKAY);
    wait_clear(0);
    axi_wr(ACC_IER_OFS, 32'h00000003, ACC_RESP_OKAY);
    repeat (20) @(posedge core_clk);
    chk(irq === 1'b1, "interrupt not held");
    axi_wr(ACC_IER_OFS, 32'h00000000, ACC_RESP_OKAY);
    axi_rd(ACC_IMR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h3, "mask after enable");
    axi_wr(ACC_IDR_OFS, 32'h00000001, ACC_RESP_OKAY);
    axi_rd(ACC_IMR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h2, "mask after disable");
    axi_rd(ACC_ISR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h2 && irq === 1'b1, "status after disable");
    axi_wr(ACC_IDR_OFS, 32'h00000002, ACC_RESP_OKAY);
    repeat (2) @(posedge core_clk);
    chk(irq === 1'b0, "interrupt after last clear");
  endtask : irq_masking
  // A low clock enable in mid-measurement must stretch the startup wait.
  task automatic ce_freeze;
    logic [31:0] d;
    axi_wr(ACC_CTRL_OFS, 32'h00000001, ACC_RESP_OKAY);
    ce <= 1'b0;
    repeat (30) @(posedge core_clk);
    ce <= 1'b1;
    axi_rd(ACC_CTRL_OFS, d, ACC_RESP_OKAY);
    chk(d[0] === 1'b1, "measurement ran while clock enable low");
    wait_clear(0);
  endtask : ce_freeze
  // An event is ignored until the trigger enable is set.
  task automatic event_single;
    logic [31:0] d;
    int base;
    axi_wr(ACC_CONF0_OFS + 8'h0C, 32'h00000003, ACC_RESP_OKAY);
    axi_wr(ACC_ICR_OFS, 32'h0000000F, ACC_RESP_OKAY);
    base = ev_cnt;
    pulse_event();
    repeat (30) @(posedge core_clk);
    axi_rd(ACC_ISR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h0, "event ran while disabled");
    axi_wr(ACC_CTRL_OFS, 32'h00000004, ACC_RESP_OKAY);
    pulse_event();
    axi_rd(ACC_CTRL_OFS, d, ACC_RESP_OKAY);
    chk(d[1] === 1'b1, "event start not set");
    wait_clear(1);
    axi_rd(ACC_STAT_OFS, d, ACC_RESP_OKAY);
    chk(d[3] === 1'b1, "event comparison result");
    axi_rd(ACC_ISR_OFS, d, ACC_RESP_OKAY);
    chk(d[3:0] === 4'h8, "event done flags");
    chk(ev_cnt === base, "event with output off");
  endtask : event_single
  // =====================================================================
  // Main sequence and verdict
  task automatic report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    fire = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h0;
    pos_lvl = {8'h1E, 8'hC8, 8'h64, 8'h64};
    neg_lvl = {8'h14, 8'h0A, 8'h32, 8'h32};
    ref_lvl = 8'h78;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check_reset_and_map();
    user_single();
    irq_masking();
    ce_freeze();
    event_single();
    report_and_stop();
  end
endmodule : analog_comparator_control_tb
`default_nettype wire
